// ==== audio_tx_regs_pkg.sv ====
// constants for the transmitter buffer, handoff and interrupt register group
package audio_tx_regs_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [6:0] IRQ2_STATUS_OFS = 7'h08;
   localparam logic [6:0] IRQ2_MASK_OFS = 7'h0C;
   localparam logic [6:0] MODE_HIGH_OFS = 7'h0D;
   localparam logic [6:0] MODE_LOW_OFS = 7'h0E;
   localparam logic [6:0] CS_CTRL_OFS = 7'h12;
   localparam logic [6:0] USER_CTRL_OFS = 7'h13;
   localparam logic [6:0] WINDOW_FIRST_OFS = 7'h20;
   localparam logic [6:0] WINDOW_LAST_OFS = 7'h37;
   localparam logic [6:0] ID_OFS = 7'h7F;

   // ------------------------------------------------------------
   // field positions and writable-bit masks
   // ------------------------------------------------------------
   localparam int HANDOFF_BIT = 2;
   localparam int BUFFER_WINDOW_SELECT_BIT = 5;
   localparam int CS_BLOCK_BIT = 2;
   localparam int CAM_BIT = 1;
   localparam int UD_BIT = 4;
   localparam int UBM_MSB = 3;
   localparam int UBM_LSB = 2;
   localparam int U_BLOCK_BIT = 0;
   localparam logic [7:0] IRQ2_BITS_MASK = 8'h04;
   localparam logic [7:0] CS_CTRL_BITS_MASK = 8'h26;
   localparam logic [7:0] USER_CTRL_BITS_MASK = 8'h1D;

   // ------------------------------------------------------------
   // reset values, sizes, encodings
   // ------------------------------------------------------------
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int BUF_BYTES = 24;
   localparam logic [1:0] IRQ_RISE = 2'h0;
   localparam logic [1:0] IRQ_FALL = 2'h1;
   localparam logic [1:0] IRQ_LEVEL = 2'h2;
   localparam logic [1:0] UBM_ZEROS = 2'h0;
   localparam logic [1:0] UBM_BLOCK = 2'h1;

endpackage : audio_tx_regs_pkg

// ==== audio_tx_links.sv ====
// interfaces between the register group and its copy engine and irq detector
`timescale 1ns/1ps

interface buffer_copy_if #(parameter int DEPTH = 24);
   localparam int IW = $clog2(DEPTH);
   logic start;
   logic busy;
   logic [IW-1:0] e_idx;
   logic [7:0] e_byte;
   logic [IW-1:0] f_idx;
   logic [7:0] f_byte;
   modport engine(input start, output busy, output e_idx, input e_byte,
                  input f_idx, output f_byte);
   modport owner(output start, input busy, input e_idx, output e_byte,
                 output f_idx, input f_byte);
endinterface : buffer_copy_if

interface irq_source_if;
   logic [1:0] mode;
   logic enable;
   logic source;
   logic read_clear;
   logic flag;
   modport detector(input mode, input enable, input source,
                    input read_clear, output flag);
   modport owner(output mode, output enable, output source,
                 output read_clear, input flag);
endinterface : irq_source_if

// ==== buffer_handoff_engine.sv ====
// copies an E buffer into its F buffer one byte per clock
`timescale 1ns/1ps

module buffer_handoff_engine #(
   parameter int DEPTH = 24
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // buffer pair
   buffer_copy_if.engine cp
);
   localparam int IW = $clog2(DEPTH);
   localparam logic [IW-1:0] LAST_IDX = IW'(DEPTH - 1);

   typedef enum logic {IDLE, COPY} copy_state_e;

   copy_state_e state_r, state_nxt;
   logic [IW-1:0] idx_r, idx_nxt;
   logic [7:0] f_mem_r [DEPTH];
   logic [7:0] f_mem_nxt [DEPTH];

   assign cp.busy = (state_r == COPY);
   assign cp.e_idx = idx_r;
   assign cp.f_byte = f_mem_r[cp.f_idx];

   // a start while copying is dropped: the block in flight finishes first
   always_comb begin
      state_nxt = state_r;
      idx_nxt = idx_r;
      f_mem_nxt = f_mem_r;
      unique case (state_r)
         IDLE: begin
            if (cp.start) begin
               state_nxt = COPY;
               idx_nxt = '0;
            end
         end
         COPY: begin
            f_mem_nxt[idx_r] = cp.e_byte;
            if (idx_r == LAST_IDX) begin
               state_nxt = IDLE;
            end else begin
               idx_nxt = idx_r + 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= IDLE;
         idx_r <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            f_mem_r[i] <= 8'h00;
         end
      end else begin
         state_r <= state_nxt;
         idx_r <= idx_nxt;
         f_mem_r <= f_mem_nxt;
      end
   end

endmodule : buffer_handoff_engine

// ==== irq_edge_detector.sv ====
// sticky interrupt flag with rising, falling or level capture
`timescale 1ns/1ps

module irq_edge_detector (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // source and control
   irq_source_if.detector ir
);
   logic src_d_r, src_d_nxt;
   logic flag_r, flag_nxt;
   logic event_hit;

   always_comb begin
      unique case (ir.mode)
         audio_tx_regs_pkg::IRQ_RISE: event_hit = ir.source & ~src_d_r;
         audio_tx_regs_pkg::IRQ_FALL: event_hit = ~ir.source & src_d_r;
         audio_tx_regs_pkg::IRQ_LEVEL: event_hit = ir.source;
         default: event_hit = 1'b0;
      endcase
      src_d_nxt = ir.source;
      // masked flags stay zero; a new event beats the read clear
      if (!ir.enable) begin
         flag_nxt = 1'b0;
      end else begin
         flag_nxt = (flag_r & ~ir.read_clear) | event_hit;
      end
   end

   assign ir.flag = flag_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         src_d_r <= 1'b0;
         flag_r <= 1'b0;
      end else begin
         src_d_r <= src_d_nxt;
         flag_r <= flag_nxt;
      end
   end

endmodule : irq_edge_detector

// ==== audio_tx_buffer_irq_mode_regs.sv ====
// control-port registers for channel-status/user buffers and handoff irq
//
// Functional notes
// - mode high and low bits form code
// - code 00 flags on condition arrival
// - code 01 flags on condition removal
// - code 10 flags while condition holds
// - irq pin polarity from polarity input only
// - both mode registers reset to zero
// - window select: 0 channel status, 1 user
// - two separate buffers, one visible at once
// - channel-status handoff block bit stops copies
// - access width bit: one or two bytes
// - user bits from pin or buffer
// - manager mode: zeros, block, reserved codes
// - user handoff block only in block mode
// - window at 20h to 37h shows E buffer
// - read-only part and revision code at 7Fh
// - handoff flag event taken from user copy busy
// - mask bit gates flag and irq pin
// - status read clears, level source persists
`timescale 1ns/1ps

module audio_tx_buffer_irq_mode_regs #(
   parameter int DEPTH = audio_tx_regs_pkg::BUF_BYTES,
   parameter logic [3:0] PART_CODE = 4'h5,  // arbitrary value
   parameter logic [3:0] REVISION = 4'h3    // arbitrary value
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // block timing from the transmitter
   input wire logic cs_block_start,
   input wire logic user_block_start,
   input wire logic [7:0] tx_bit_index,
   input wire logic user_pin_bit,
   // transmitted bits
   output logic cs_bit_out,
   output logic user_bit_out,
   // status and interrupt
   output logic cs_handoff_busy,
   output logic user_handoff_busy,
   input wire logic irq_active_high,
   output logic irq_out
);
   localparam int IW = $clog2(DEPTH);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic in_window(input logic [6:0] a);
      in_window = (a >= audio_tx_regs_pkg::WINDOW_FIRST_OFS) &&
                  (a <= audio_tx_regs_pkg::WINDOW_LAST_OFS);
   endfunction : in_window

   function automatic logic [IW-1:0] window_index(input logic [6:0] a);
      logic [6:0] off;
      off = a - audio_tx_regs_pkg::WINDOW_FIRST_OFS;
      window_index = off[IW-1:0];
   endfunction : window_index

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   logic [7:0] mask_r, mask_nxt;
   logic [7:0] mode_high_r, mode_high_nxt;
   logic [7:0] mode_low_r, mode_low_nxt;
   logic [7:0] cs_ctrl_r, cs_ctrl_nxt;
   logic [7:0] user_ctrl_r, user_ctrl_nxt;

   logic buffer_window_select;
   logic cs_buffer_handoff_block;
   logic cs_access_width;
   logic user_bit_source_select;
   logic [1:0] user_bit_manager_mode;
   logic user_buffer_handoff_block;
   logic user_buffer_handoff_enable;
   logic user_block_mode;

   assign buffer_window_select = cs_ctrl_r[audio_tx_regs_pkg::BUFFER_WINDOW_SELECT_BIT];
   assign cs_buffer_handoff_block =
      cs_ctrl_r[audio_tx_regs_pkg::CS_BLOCK_BIT];
   assign cs_access_width = cs_ctrl_r[audio_tx_regs_pkg::CAM_BIT];
   assign user_bit_source_select = user_ctrl_r[audio_tx_regs_pkg::UD_BIT];
   assign user_bit_manager_mode =
      user_ctrl_r[audio_tx_regs_pkg::UBM_MSB:audio_tx_regs_pkg::UBM_LSB];
   assign user_buffer_handoff_block =
      user_ctrl_r[audio_tx_regs_pkg::U_BLOCK_BIT];
   assign user_buffer_handoff_enable =
      mask_r[audio_tx_regs_pkg::HANDOFF_BIT];
   // reserved manager codes behave as the all-zero mode
   assign user_block_mode =
      (user_bit_manager_mode == audio_tx_regs_pkg::UBM_BLOCK);

   // only defined bits are stored, so reserved bits read back as zero
   always_comb begin
      mask_nxt = mask_r;
      mode_high_nxt = mode_high_r;
      mode_low_nxt = mode_low_r;
      cs_ctrl_nxt = cs_ctrl_r;
      user_ctrl_nxt = user_ctrl_r;
      if (reg_wr) begin
         unique case (reg_addr)
            audio_tx_regs_pkg::IRQ2_MASK_OFS: begin
               mask_nxt = reg_wdata & audio_tx_regs_pkg::IRQ2_BITS_MASK;
            end
            audio_tx_regs_pkg::MODE_HIGH_OFS: begin
               mode_high_nxt = reg_wdata & audio_tx_regs_pkg::IRQ2_BITS_MASK;
            end
            audio_tx_regs_pkg::MODE_LOW_OFS: begin
               mode_low_nxt = reg_wdata & audio_tx_regs_pkg::IRQ2_BITS_MASK;
            end
            audio_tx_regs_pkg::CS_CTRL_OFS: begin
               cs_ctrl_nxt = reg_wdata & audio_tx_regs_pkg::CS_CTRL_BITS_MASK;
            end
            audio_tx_regs_pkg::USER_CTRL_OFS: begin
               user_ctrl_nxt =
                  reg_wdata & audio_tx_regs_pkg::USER_CTRL_BITS_MASK;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mask_r <= audio_tx_regs_pkg::REG_RESET;
         mode_high_r <= audio_tx_regs_pkg::REG_RESET;
         mode_low_r <= audio_tx_regs_pkg::REG_RESET;
         cs_ctrl_r <= audio_tx_regs_pkg::REG_RESET;
         user_ctrl_r <= audio_tx_regs_pkg::REG_RESET;
      end else begin
         mask_r <= mask_nxt;
         mode_high_r <= mode_high_nxt;
         mode_low_r <= mode_low_nxt;
         cs_ctrl_r <= cs_ctrl_nxt;
         user_ctrl_r <= user_ctrl_nxt;
      end
   end

   // ------------------------------------------------------------
   // E buffers behind the shared window
   // ------------------------------------------------------------
   logic [7:0] cs_e_r [DEPTH];
   logic [7:0] cs_e_nxt [DEPTH];
   logic [7:0] user_e_r [DEPTH];
   logic [7:0] user_e_nxt [DEPTH];
   logic [7:0] pair_byte_r, pair_byte_nxt;
   logic [IW-1:0] pair_idx_r, pair_idx_nxt;
   logic pair_valid_r, pair_valid_nxt;
   logic win_wr;
   logic [IW-1:0] win_idx;

   assign win_wr = reg_wr && in_window(reg_addr);
   assign win_idx = window_index(reg_addr);

   // in two-byte mode the even byte waits for its odd partner, so both bytes
   // of a pair enter the E buffer on the same clock edge
   always_comb begin
      cs_e_nxt = cs_e_r;
      user_e_nxt = user_e_r;
      pair_byte_nxt = pair_byte_r;
      pair_idx_nxt = pair_idx_r;
      pair_valid_nxt = pair_valid_r;
      if (win_wr && !buffer_window_select) begin
         if (!cs_access_width) begin
            cs_e_nxt[win_idx] = reg_wdata;
            pair_valid_nxt = 1'b0;
         end else if (!win_idx[0]) begin
            pair_byte_nxt = reg_wdata;
            pair_idx_nxt = win_idx;
            pair_valid_nxt = 1'b1;
         end else begin
            if (pair_valid_r && (pair_idx_r == (win_idx ^ 1'b1))) begin
               cs_e_nxt[pair_idx_r] = pair_byte_r;
            end
            cs_e_nxt[win_idx] = reg_wdata;
            pair_valid_nxt = 1'b0;
         end
      end else if (win_wr && user_block_mode) begin
         user_e_nxt[win_idx] = reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < DEPTH; i++) begin
            cs_e_r[i] <= 8'h00;
            user_e_r[i] <= 8'h00;
         end
         pair_byte_r <= 8'h00;
         pair_idx_r <= '0;
         pair_valid_r <= 1'b0;
      end else begin
         cs_e_r <= cs_e_nxt;
         user_e_r <= user_e_nxt;
         pair_byte_r <= pair_byte_nxt;
         pair_idx_r <= pair_idx_nxt;
         pair_valid_r <= pair_valid_nxt;
      end
   end

   // ------------------------------------------------------------
   // E to F handoff engines
   // ------------------------------------------------------------
   buffer_copy_if #(.DEPTH(DEPTH)) cs_cp();
   buffer_copy_if #(.DEPTH(DEPTH)) user_cp();

   assign cs_cp.start = cs_block_start && !cs_buffer_handoff_block;
   // the block bit only matters in block mode; outside it nothing copies
   assign user_cp.start = user_block_start && user_block_mode &&
                          !user_buffer_handoff_block;
   assign cs_cp.e_byte = cs_e_r[cs_cp.e_idx];
   assign user_cp.e_byte = user_e_r[user_cp.e_idx];
   assign cs_cp.f_idx = tx_bit_index[IW+2:3];
   assign user_cp.f_idx = tx_bit_index[IW+2:3];

   buffer_handoff_engine #(.DEPTH(DEPTH)) cs_engine (
      .clk(clk),
      .reset(reset),
      .cp(cs_cp)
   );

   buffer_handoff_engine #(.DEPTH(DEPTH)) user_engine (
      .clk(clk),
      .reset(reset),
      .cp(user_cp)
   );

   assign cs_handoff_busy = cs_cp.busy;
   assign user_handoff_busy = user_cp.busy;

   // ------------------------------------------------------------
   // transmitted bit selection
   // ------------------------------------------------------------
   logic cs_bit_r, cs_bit_nxt;
   logic user_bit_r, user_bit_nxt;

   always_comb begin
      cs_bit_nxt = cs_cp.f_byte[tx_bit_index[2:0]];
      if (!user_bit_source_select) begin
         user_bit_nxt = user_pin_bit;
      end else if (user_block_mode) begin
         user_bit_nxt = user_cp.f_byte[tx_bit_index[2:0]];
      end else begin
         user_bit_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cs_bit_r <= 1'b0;
         user_bit_r <= 1'b0;
      end else begin
         cs_bit_r <= cs_bit_nxt;
         user_bit_r <= user_bit_nxt;
      end
   end

   assign cs_bit_out = cs_bit_r;
   assign user_bit_out = user_bit_r;

   // ------------------------------------------------------------
   // user handoff interrupt
   // ------------------------------------------------------------
   irq_source_if user_ir();
   logic status_read;

   assign status_read = reg_rd &&
                        (reg_addr == audio_tx_regs_pkg::IRQ2_STATUS_OFS);
   assign user_ir.mode = {mode_high_r[audio_tx_regs_pkg::HANDOFF_BIT],
                          mode_low_r[audio_tx_regs_pkg::HANDOFF_BIT]};
   assign user_ir.enable = user_buffer_handoff_enable;
   assign user_ir.source = user_cp.busy;
   assign user_ir.read_clear = status_read;

   // detector covers rise, fall, level and the silent reserved code
   irq_edge_detector user_irq (
      .clk(clk),
      .reset(reset),
      .ir(user_ir)
   );

   logic irq_r, irq_nxt;

   assign irq_nxt = user_ir.flag ~^ irq_active_high;

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   assign irq_out = irq_r;

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   logic [7:0] rdata_r, rdata_nxt;
   logic [7:0] status_byte;

   assign status_byte = {5'h00, user_ir.flag, 2'h0};

   always_comb begin
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         if (in_window(reg_addr)) begin
            if (!buffer_window_select) begin
               rdata_nxt = cs_e_r[win_idx];
            end else if (user_block_mode) begin
               rdata_nxt = user_e_r[win_idx];
            end else begin
               rdata_nxt = 8'h00;
            end
         end else begin
            unique case (reg_addr)
               audio_tx_regs_pkg::IRQ2_STATUS_OFS: rdata_nxt = status_byte;
               audio_tx_regs_pkg::IRQ2_MASK_OFS: rdata_nxt = mask_r;
               audio_tx_regs_pkg::MODE_HIGH_OFS: rdata_nxt = mode_high_r;
               audio_tx_regs_pkg::MODE_LOW_OFS: rdata_nxt = mode_low_r;
               audio_tx_regs_pkg::CS_CTRL_OFS: rdata_nxt = cs_ctrl_r;
               audio_tx_regs_pkg::USER_CTRL_OFS: rdata_nxt = user_ctrl_r;
               audio_tx_regs_pkg::ID_OFS: begin
                  rdata_nxt = {PART_CODE, REVISION};
               end
               default: rdata_nxt = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

endmodule : audio_tx_buffer_irq_mode_regs

// ==== audio_tx_regs_properties.sv ====
// concurrent checks on the ports of the buffer and handoff register group
`timescale 1ns/1ps

module audio_tx_regs_checker #(
   parameter logic [3:0] PART_CODE = 4'h5,  // arbitrary value
   parameter logic [3:0] REVISION = 4'h3    // arbitrary value
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [6:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // handoff and interrupt
   input wire logic cs_block_start,
   input wire logic user_block_start,
   input wire logic cs_handoff_busy,
   input wire logic user_handoff_busy,
   input wire logic irq_active_high,
   input wire logic irq_out
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // ------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------
   // one pass over all 24 bytes, then idle
   sequence copy_run(b);
      b [*8] ##1 b [*8] ##1 b [*8] ##1 !b;
   endsequence
   sequence rd_of(a);
      reg_rd && reg_addr == a;
   endsequence

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   cs_copy_len_a: assert property (
      $rose(cs_handoff_busy) |-> copy_run(cs_handoff_busy))
      else $error("cs copy length wrong");
   user_copy_len_a: assert property (
      $rose(user_handoff_busy) |-> copy_run(user_handoff_busy))
      else $error("user copy length wrong");
   cs_copy_cause_a: assert property (
      $rose(cs_handoff_busy) |-> $past(cs_block_start))
      else $error("cs copy without start");
   user_copy_cause_a: assert property (
      $rose(user_handoff_busy) |-> $past(user_block_start))
      else $error("user copy without start");
   id_value_a: assert property (
      rd_of(audio_tx_regs_pkg::ID_OFS) |=>
      reg_rdata == {PART_CODE, REVISION})
      else $error("id register wrong");
   status_pin_a: assert property (
      rd_of(audio_tx_regs_pkg::IRQ2_STATUS_OFS) |=>
      reg_rdata[audio_tx_regs_pkg::HANDOFF_BIT] ==
      (irq_out ~^ $past(irq_active_high)))
      else $error("irq pin disagrees with status");
   rdata_hold_a: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
   unmapped_zero_a: assert property (
      rd_of(7'h40) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : audio_tx_regs_checker

bind audio_tx_buffer_irq_mode_regs audio_tx_regs_checker #(
   .PART_CODE(PART_CODE),
   .REVISION(REVISION)
) chk_inst (
   .clk(clk),
   .reset(reset),
   .reg_addr(reg_addr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .cs_block_start(cs_block_start),
   .user_block_start(user_block_start),
   .cs_handoff_busy(cs_handoff_busy),
   .user_handoff_busy(user_handoff_busy),
   .irq_active_high(irq_active_high),
   .irq_out(irq_out)
);

// ==== frame_source.sv ====
// far-side model: block boundary pulses, bit position and user pin
`timescale 1ns/1ps

module frame_source (
   // clock
   input wire logic clk,
   // block timing toward the register group
   output logic cs_block_start,
   output logic user_block_start,
   output logic [7:0] tx_bit_index,
   output logic user_pin_bit
);
   initial begin
      cs_block_start = 1'b0;
      user_block_start = 1'b0;
      tx_bit_index = 8'h00;
   end
   // pin pattern differs from buffer data so a wrong source shows
   always_comb user_pin_bit = tx_bit_index[1];

   // one-cycle boundary pulse, raised just after an edge
   task pulse(input logic user);
      if (user) begin
         user_block_start = 1'b1;
      end else begin
         cs_block_start = 1'b1;
      end
      @(posedge clk);
      #1;
      user_block_start = 1'b0;
      cs_block_start = 1'b0;
   endtask : pulse

   task set_index(input logic [7:0] i);
      tx_bit_index = i;
   endtask : set_index
endmodule : frame_source

// ==== audio_tx_buffer_irq_mode_regs_tb.sv ====
// self-checking bench for the buffer and handoff irq register group
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
   err_count++; $display("unexpected at %0t: got %h want %h", \
   $time, a, b); end end

module audio_tx_buffer_irq_mode_regs_tb;
   logic clk;
   logic reset;
   logic [6:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_wdata;
   logic irq_active_high;
   logic [7:0] reg_rdata, rd_val, tx_bit_index;
   logic cs_block_start, user_block_start, user_pin_bit, exp;
   logic cs_bit_out, user_bit_out, cs_handoff_busy, user_handoff_busy;
   logic irq_out;
   logic [6:0] ma [4] = '{7'h12, 7'h13, 7'h0D, 7'h0E};
   logic [7:0] mv [4] = '{8'h26, 8'h1D, 8'h04, 8'h04};
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;

   always #2 clk = ~clk;

   audio_tx_buffer_irq_mode_regs audio_tx_buffer_irq_mode_regs_inst (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .cs_block_start(cs_block_start), .user_block_start(user_block_start),
      .tx_bit_index(tx_bit_index), .user_pin_bit(user_pin_bit),
      .cs_bit_out(cs_bit_out), .user_bit_out(user_bit_out),
      .cs_handoff_busy(cs_handoff_busy),
      .user_handoff_busy(user_handoff_busy),
      .irq_active_high(irq_active_high), .irq_out(irq_out));

   frame_source frame_source_inst (
      .clk(clk), .cs_block_start(cs_block_start),
      .user_block_start(user_block_start), .tx_bit_index(tx_bit_index),
      .user_pin_bit(user_pin_bit));

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   // an idle cycle after each access keeps strobes from double edges
   task wr(input logic [6:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      @(posedge clk);
      #1;
   endtask : wr
   task rd(input logic [6:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
      @(posedge clk);
      #1;
   endtask : rd
   task chk_rd(input logic [6:0] a, input logic [7:0] e);
      rd(a, rd_val);
      `CHK(rd_val, e)
   endtask : chk_rd
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         stop_test();
      end
   end

   initial begin
      clk = 1'b0;
      reset = 1'b1;
      reg_addr = 7'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      irq_active_high = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      reset = 1'b0;
      foreach (ma[i]) chk_rd(ma[i], 8'h00);
      chk_rd(7'h08, 8'h00);
      chk_rd(7'h7F, 8'h53);
      wr(7'h7F, 8'h00);
      chk_rd(7'h7F, 8'h53);
      wr(7'h40, 8'hFF);
      chk_rd(7'h40, 8'h00);
      foreach (ma[i]) begin
         wr(ma[i], 8'hFF);
         chk_rd(ma[i], mv[i]);
         wr(ma[i], 8'h00);
      end
      $display("test regs done");
      for (int i = 0; i < 24; i++) wr(7'h20 + i, 8'h40 + i);
      for (int i = 0; i < 24; i++) chk_rd(7'h20 + i, 8'h40 + i);
      wr(7'h12, 8'h20);
      chk_rd(7'h20, 8'h00);
      wr(7'h13, 8'h14);
      wr(7'h20, 8'hA5);
      chk_rd(7'h20, 8'hA5);
      wr(7'h12, 8'h00);
      chk_rd(7'h20, 8'h40);
      $display("test window done");
      frame_source_inst.pulse(1'b0);
      step(1);
      `CHK(cs_handoff_busy, 1'b1)
      step(24);
      `CHK(cs_handoff_busy, 1'b0)
      frame_source_inst.set_index(8'h0E);
      step(1);
      `CHK(cs_bit_out, 1'b1)
      frame_source_inst.set_index(8'h09);
      step(1);
      `CHK(cs_bit_out, 1'b0)
      wr(7'h12, 8'h04);
      frame_source_inst.pulse(1'b0);
      step(1);
      `CHK(cs_handoff_busy, 1'b0)
      wr(7'h12, 8'h02);
      wr(7'h20, 8'hAA);
      chk_rd(7'h20, 8'h40);
      wr(7'h21, 8'hBB);
      chk_rd(7'h20, 8'hAA);
      chk_rd(7'h21, 8'hBB);
      wr(7'h12, 8'h00);
      $display("test cs done");
      // code 4 repeats rising mode with the source masked off
      wr(7'h0C, 8'h04);
      for (int c = 0; c < 5; c++) begin
         irq_active_high = (c != 1);
         wr(7'h0D, {5'h00, c[1], 2'h0});
         wr(7'h0E, {5'h00, c[0], 2'h0});
         if (c == 4) wr(7'h0C, 8'h00);
         rd(7'h08, rd_val);
         frame_source_inst.pulse(1'b1);
         step(3);
         exp = (c == 0 || c == 2);
         `CHK(irq_out, exp ~^ irq_active_high)
         step(30);
         exp = (c < 3);
         `CHK(irq_out, exp ~^ irq_active_high)
         chk_rd(7'h08, {5'h00, exp, 2'h0});
         chk_rd(7'h08, 8'h00);
      end
      $display("test irq done");
      frame_source_inst.set_index(8'h00);
      step(1);
      `CHK(user_bit_out, 1'b1)
      frame_source_inst.set_index(8'h01);
      step(1);
      `CHK(user_bit_out, 1'b0)
      wr(7'h13, 8'h10);
      frame_source_inst.set_index(8'h00);
      step(1);
      `CHK(user_bit_out, 1'b0)
      wr(7'h13, 8'h00);
      frame_source_inst.set_index(8'h02);
      step(1);
      `CHK(user_bit_out, 1'b1)
      wr(7'h13, 8'h15);
      frame_source_inst.pulse(1'b1);
      step(1);
      `CHK(user_handoff_busy, 1'b0)
      $display("test user done");
      stop_test();
   end
endmodule : audio_tx_buffer_irq_mode_regs_tb
